// ==== core/pme_fence_defs.svh ====
// constants for the switch power-management message and fence logic
// assumes a 200 MHz core clock and an axi4-lite register master
// Overview of operation
// - no pme messages in cold state
// - downstream ports send pme from d3hot
// - pme retry timer resends while status set
// - turn-off forwarded to all active ports
// - ack upstream only after all port acks or ack timeouts
// - turn-off accepted in any power state
// - upstream tlp abandons ack aggregation
// - tlps after scheduled ack may drop
// - tlp for switch handled normally
// - tlp to port forwarded, retrain if l2
// - abandon keeps downstream handshake running
// - ack timeout forces l2 and ack
// - d0 uninitialized re-arms fence, clears upstream l23
// - power budget capability hidden after reset
// - one header plus eight value registers
// - header read-only, eeprom loaded only
// - value writes need unlock bit set
`ifndef PME_FENCE_DEFS_SVH
`define PME_FENCE_DEFS_SVH
`define NPORTS 4
`define NDV 8
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_MASK 8'h08
`define A_PWRST 8'h0c
`define A_PME_FLAGS 8'h10
`define A_RETRY_TO 8'h14
`define A_ACK_TO 8'h18
`define A_NEXT_PTR 8'h1c
`define A_PBHDR 8'h20
`define A_DV0 8'h40
`define B_UNLOCK 0
`define B_PBVIS 1
`define EV_ACKUP 0
`define EV_ABANDON 1
`define EV_TIMEOUT 2
`define EV_PME 3
`define NEV 4
`define PB_CAP_OFS 12'h100
`define RETRY_RST 16'h0100
`define ACKTO_RST 16'h0100
`define OKAY 2'b00
`define SLVERR 2'b10
`endif

// ==== core/pme_fence_pkg.sv ====
// types for the switch power-management message and fence logic
// assumes the constants header is included by the users
package pme_fence_pkg;
    typedef enum logic [1:0] {D0_UNINIT, D0_ACTIVE, D3_HOT, D3_COLD} pwr_t;
    typedef enum logic [1:0] {AG_IDLE, AG_WAIT, AG_DONE} agg_t;
    typedef enum logic [1:0] {LK_L0, LK_TURNOFF, LK_L23, LK_RETRAIN} lnk_t;
endpackage : pme_fence_pkg

// ==== core/pme_fence.sv ====
// switch pme generation, turn-off fence and power budget registers
// assumes link layers give one-cycle message pulses on SYS_CLK
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pme_fence_defs.svh"
module pme_fence (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic [3:0] HP_EVENT,
    input wire logic [3:0] PORT_ACTIVE,
    input wire logic TURNOFF_RX,
    input wire logic UP_TLP_RX,
    input wire logic UP_TLP_SELF,
    input wire logic [3:0] UP_TLP_PORT,
    input wire logic [3:0] ACK_RX,
    input wire logic [3:0] LINK_UP,
    input wire logic EE_LOAD,
    input wire logic [31:0] EE_HDR,
    output logic [3:0] PME_TX,
    output logic [3:0] TURNOFF_TX,
    output logic ACK_TX,
    output logic UP_L23,
    output logic TLP_DROP,
    output logic TLP_SELF_ACCEPT,
    output logic [3:0] TLP_FWD,
    output logic [3:0] RETRAIN,
    output logic IRQ
);
    typedef struct packed {
        logic awr; logic wr; logic bv; logic arr; logic rv;
        logic [7:0] aw; logic [31:0] wd; logic [3:0] ws; logic [31:0] rd; logic [1:0] br; logic [1:0] rr;
        logic [31:0] ctrl; logic [`NEV-1:0] stat; logic [`NEV-1:0] mask;
        pme_fence_pkg::pwr_t pw; logic [3:0] pflag; logic [15:0] rto; logic [15:0] ato;
        logic [11:0] nxt; logic [31:0] hdr; logic [`NDV-1:0][31:0] dv;
        logic [3:0][15:0] rtmr; logic [3:0][15:0] atmr;
        pme_fence_pkg::agg_t ag; logic [3:0] need; logic [3:0] got;
        pme_fence_pkg::lnk_t [3:0] lk; logic [3:0] pend;
        logic [3:0] pme_tx; logic [3:0] to_tx; logic ack_tx; logic l23; logic drop; logic self;
        logic [3:0] fwd; logic [3:0] rtr; logic irq;
    } st_t;
    st_t q, d;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction : merge

    function automatic logic is_dv(input logic [7:0] a);
        is_dv = (a >= `A_DV0) && (a < 8'(`A_DV0 + 4 * `NDV));
    endfunction : is_dv

    logic [`NEV-1:0] ev;
    logic [2:0] dvi;
    logic [2:0] rdi;
    always_comb begin
        d = q;
        ev = '0;
        dvi = q.aw[4:2];
        rdi = ARADDR[4:2];
        d.pme_tx = '0;
        d.to_tx = '0;
        d.ack_tx = 1'b0;
        d.drop = 1'b0;
        d.self = 1'b0;
        d.fwd = '0;
        d.rtr = '0;
        // axi write: address and data in either order
        if (AWVALID && q.awr) begin
            d.aw = AWADDR;
            d.awr = 1'b0;
        end
        if (WVALID && q.wr) begin
            d.wd = WDATA;
            d.ws = WSTRB;
            d.wr = 1'b0;
        end
        if (!q.awr && !q.wr && !q.bv) begin
            d.bv = 1'b1;
            d.br = `OKAY;
            case (q.aw)
                `A_CTRL: d.ctrl = merge(q.ctrl, q.wd, q.ws);
                `A_STAT: d.stat = q.stat & ~q.wd[`NEV-1:0];
                `A_MASK: d.mask = q.wd[`NEV-1:0];
                `A_PWRST: d.pw = pme_fence_pkg::pwr_t'(q.wd[1:0]);
                `A_PME_FLAGS: d.pflag = q.pflag & ~q.wd[3:0];
                `A_RETRY_TO: d.rto = q.wd[15:0];
                `A_ACK_TO: d.ato = q.wd[15:0];
                `A_NEXT_PTR: d.nxt = q.wd[11:0];
                `A_PBHDR: ;
                default: begin
                    if (is_dv(q.aw)) begin
                        if (q.ctrl[`B_UNLOCK]) begin
                            d.dv[dvi] = merge(q.dv[dvi], q.wd, q.ws);
                        end
                    end else begin
                        d.br = `SLVERR;
                    end
                end
            endcase
        end
        if (q.bv && BREADY) begin
            d.bv = 1'b0;
            d.awr = 1'b1;
            d.wr = 1'b1;
        end
        // axi read
        if (ARVALID && q.arr) begin
            d.arr = 1'b0;
            d.rv = 1'b1;
            d.rr = `OKAY;
            d.rd = '0;
            case (ARADDR)
                `A_CTRL: d.rd = q.ctrl;
                `A_STAT: d.rd = 32'(q.stat);
                `A_MASK: d.rd = 32'(q.mask);
                `A_PWRST: d.rd = 32'(q.pw);
                `A_PME_FLAGS: d.rd = 32'(q.pflag);
                `A_RETRY_TO: d.rd = 32'(q.rto);
                `A_ACK_TO: d.rd = 32'(q.ato);
                `A_NEXT_PTR: d.rd = 32'(q.nxt);
                `A_PBHDR: d.rd = (q.nxt == `PB_CAP_OFS) ? q.hdr : 32'h0;
                default: begin
                    if (is_dv(ARADDR)) begin
                        d.rd = (q.nxt == `PB_CAP_OFS) ? q.dv[rdi] : 32'h0;
                    end else begin
                        d.rr = `SLVERR;
                    end
                end
            endcase
        end
        if (q.rv && RREADY) begin
            d.rv = 1'b0;
            d.arr = 1'b1;
        end
        if (EE_LOAD) begin
            d.hdr = EE_HDR;
        end
        for (int p = 0; p < `NPORTS; p++) begin
            // no pme when cold, resume otherwise
            if (q.pw != pme_fence_pkg::D3_COLD) begin
                if (HP_EVENT[p] && q.pw == pme_fence_pkg::D3_HOT && !q.pflag[p]) begin
                    d.pflag[p] = 1'b1;
                    d.pme_tx[p] = 1'b1;
                    d.rtmr[p] = q.rto;
                    ev[`EV_PME] = 1'b1;
                end else if (q.pflag[p]) begin
                    // resend on expiry while status set
                    if (q.rtmr[p] == 16'h0) begin
                        d.pme_tx[p] = 1'b1;
                        d.rtmr[p] = q.rto;
                    end else begin
                        d.rtmr[p] = q.rtmr[p] - 16'h1;
                    end
                end
            end
            // downstream handshake runs regardless of abandon
            case (q.lk[p])
                pme_fence_pkg::LK_TURNOFF: begin
                    if (ACK_RX[p]) begin
                        d.lk[p] = pme_fence_pkg::LK_L23;
                        d.got[p] = 1'b1;
                    end else if (q.atmr[p] == 16'h0) begin
                        d.lk[p] = pme_fence_pkg::LK_L23;
                        d.got[p] = 1'b1;
                        ev[`EV_TIMEOUT] = 1'b1;
                    end else begin
                        d.atmr[p] = q.atmr[p] - 16'h1;
                    end
                end
                pme_fence_pkg::LK_RETRAIN: begin
                    if (LINK_UP[p]) begin
                        d.lk[p] = pme_fence_pkg::LK_L0;
                        d.fwd[p] = q.pend[p];
                        d.pend[p] = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (TURNOFF_RX && q.ag != pme_fence_pkg::AG_WAIT) begin
            d.ag = pme_fence_pkg::AG_WAIT;
            d.need = PORT_ACTIVE;
            d.got = '0;
            d.to_tx = PORT_ACTIVE;
            for (int p = 0; p < `NPORTS; p++) begin
                if (PORT_ACTIVE[p]) begin
                    d.lk[p] = pme_fence_pkg::LK_TURNOFF;
                    d.atmr[p] = q.ato;
                end
            end
        end else if (UP_TLP_RX) begin
            if (q.ag == pme_fence_pkg::AG_DONE) begin
                d.drop = 1'b1;
            end else begin
                if (q.ag == pme_fence_pkg::AG_WAIT) begin
                    d.ag = pme_fence_pkg::AG_IDLE;
                    ev[`EV_ABANDON] = 1'b1;
                end
                d.self = UP_TLP_SELF;
                for (int p = 0; p < `NPORTS; p++) begin
                    if (UP_TLP_PORT[p]) begin
                        if (q.lk[p] == pme_fence_pkg::LK_L23) begin
                            d.lk[p] = pme_fence_pkg::LK_RETRAIN;
                            d.rtr[p] = 1'b1;
                            d.pend[p] = 1'b1;
                        end else if (q.lk[p] == pme_fence_pkg::LK_RETRAIN) begin
                            d.pend[p] = 1'b1;
                        end else begin
                            d.fwd[p] = 1'b1;
                        end
                    end
                end
            end
        end else if (q.ag == pme_fence_pkg::AG_WAIT && (q.got & q.need) == q.need) begin
            // ack once every active port acked or timed out
            d.ag = pme_fence_pkg::AG_DONE;
            d.ack_tx = 1'b1;
            d.l23 = 1'b1;
            ev[`EV_ACKUP] = 1'b1;
        end
        if (q.pw == pme_fence_pkg::D0_UNINIT && q.ag == pme_fence_pkg::AG_DONE) begin
            d.ag = pme_fence_pkg::AG_IDLE;
            d.l23 = 1'b0;
        end
        // sticky events, set beats clear
        d.stat = d.stat | ev;
        d.irq = |(d.stat & d.mask);
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            q <= '0;
            q.awr <= 1'b1;
            q.wr <= 1'b1;
            q.arr <= 1'b1;
            q.rto <= `RETRY_RST;
            q.ato <= `ACKTO_RST;
        end else begin
            q <= d;
        end
    end

    assign AWREADY = q.awr;
    assign WREADY = q.wr;
    assign BVALID = q.bv;
    assign BRESP = q.br;
    assign ARREADY = q.arr;
    assign RVALID = q.rv;
    assign RDATA = q.rd;
    assign RRESP = q.rr;
    assign PME_TX = q.pme_tx;
    assign TURNOFF_TX = q.to_tx;
    assign ACK_TX = q.ack_tx;
    assign UP_L23 = q.l23;
    assign TLP_DROP = q.drop;
    assign TLP_SELF_ACCEPT = q.self;
    assign TLP_FWD = q.fwd;
    assign RETRAIN = q.rtr;
    assign IRQ = q.irq;

    cold_quiet_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        $past(q.pw) == pme_fence_pkg::D3_COLD |-> PME_TX == 4'h0) else $error("pme sent in cold state");
    turnoff_fwd_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        TURNOFF_RX && q.ag != pme_fence_pkg::AG_WAIT |=> TURNOFF_TX == $past(PORT_ACTIVE)) else $error("no broadcast");
    // ack only with all acks in
    sequence agg_full_s;
        q.ag == pme_fence_pkg::AG_WAIT && (q.got & q.need) == q.need;
    endsequence
    ack_gate_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        $rose(ACK_TX) |-> $past(q.ag == pme_fence_pkg::AG_WAIT && (q.got & q.need) == q.need)) else $error("early ack");
    abandon_agg_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        q.ag == pme_fence_pkg::AG_WAIT && UP_TLP_RX && !TURNOFF_RX |=> q.ag == pme_fence_pkg::AG_IDLE && !ACK_TX)
        else $error("aggregation not abandoned");
    drop_when_done_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        TLP_DROP |-> $past(q.ag) == pme_fence_pkg::AG_DONE) else $error("drop before ack");
    ack_timeout_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        q.lk[0] == pme_fence_pkg::LK_TURNOFF && q.atmr[0] == 16'h0 && !TURNOFF_RX
        |=> q.lk[0] == pme_fence_pkg::LK_L23 && q.got[0])
        else $error("ack timeout not taken");
    pme_retry_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        q.pflag[1] && q.rtmr[1] == 16'h0 && q.pw != pme_fence_pkg::D3_COLD ##1 q.pflag[1] |-> PME_TX[1])
        else $error("pme not resent");
    // locked values never change by bus
    dv_lock_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        !q.ctrl[`B_UNLOCK] |=> q.dv == $past(q.dv)) else $error("locked value written");
    hidden_read_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        ARVALID && ARREADY && ARADDR == `A_PBHDR && q.nxt != `PB_CAP_OFS |=> RDATA == 32'h0)
        else $error("hidden capability visible");
endmodule : pme_fence

// ==== verification/pme_link_partner.sv ====
// downstream link partners: answer turn-off with an ack, retrain to l0 on request
// assumes one-cycle turnoff and retrain pulses on clk, sync active-high reset
`timescale 1ns/1ps
module pme_link_partner (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] turnoff_tx,
    input wire logic [3:0] retrain,
    input wire logic [3:0] silent,
    output logic [3:0] ack_rx,
    output logic [3:0] link_up
);
    logic [3:0] ack_cnt[4];
    logic [3:0] up_cnt[4];
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            ack_rx[i] <= 1'b0;
            if (srst) begin
                ack_cnt[i] <= 4'h0;
                up_cnt[i] <= 4'h0;
                link_up[i] <= 1'b1;
            end else begin
                if (turnoff_tx[i]) begin
                    ack_cnt[i] <= 4'h5;
                end else if (ack_cnt[i] != 4'h0) begin
                    ack_cnt[i] <= ack_cnt[i] - 4'h1;
                    if (ack_cnt[i] == 4'h1 && !silent[i]) begin
                        ack_rx[i] <= 1'b1;
                        link_up[i] <= 1'b0;
                    end
                end
                if (retrain[i]) begin
                    link_up[i] <= 1'b0;
                    up_cnt[i] <= 4'h6;
                end else if (up_cnt[i] != 4'h0) begin
                    up_cnt[i] <= up_cnt[i] - 4'h1;
                    if (up_cnt[i] == 4'h1) begin
                        link_up[i] <= 1'b1;
                    end
                end
            end
        end
    end
endmodule : pme_link_partner

// ==== verification/pme_fence_tb.sv ====
// self-checking bench for the pme and turn-off fence block
// assumes the link partner model and the constants header
`timescale 1ns/1ps
`include "pme_fence_defs.svh"
module pme_fence_tb;
    logic SYS_CLK = 1'b0, SRST = 1'b1, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0;
    logic RREADY = 1'b0, TURNOFF_RX = 1'b0, UP_TLP_RX = 1'b0, UP_TLP_SELF = 1'b0, EE_LOAD = 1'b0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, EE_HDR = 32'h0, RDATA, rd;
    logic [3:0] WSTRB = 4'hf, HP_EVENT = 4'h0, PORT_ACTIVE = 4'h0, UP_TLP_PORT = 4'h0, silent = 4'h0;
    logic [3:0] ACK_RX, LINK_UP, PME_TX, TURNOFF_TX, TLP_FWD, RETRAIN;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, ACK_TX, UP_L23, TLP_DROP, TLP_SELF_ACCEPT, IRQ;
    logic [1:0] BRESP, RRESP, rr;
    logic [19:0] mon;
    int errors = 0, check_count = 0, n, k;
    pme_fence uut (.*);
    pme_link_partner lp (.clk(SYS_CLK), .srst(SRST), .turnoff_tx(TURNOFF_TX), .retrain(RETRAIN),
        .silent(silent), .ack_rx(ACK_RX), .link_up(LINK_UP));
    assign mon = {TURNOFF_TX, RETRAIN, TLP_FWD, PME_TX, ACK_TX, TLP_DROP, TLP_SELF_ACCEPT, IRQ};
    always #2.5 SYS_CLK = ~SYS_CLK;
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task hang(input string m);
        errors++;
        $display("wrong value at %0t: %s timed out", $time, m);
        finish_test();
    endtask : hang
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge SYS_CLK);
        AWADDR <= a; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge SYS_CLK);
            aw = AWVALID & AWREADY; w = WVALID & WREADY; b = BVALID & BREADY;
            @(posedge SYS_CLK);
            if (aw) AWVALID <= 1'b0;
            if (w) WVALID <= 1'b0;
            if (b) begin
                BREADY <= 1'b0;
                break;
            end
        end
        if (n == 50) hang("write");
    endtask : wr
    task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ar, rv;
        @(posedge SYS_CLK);
        ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge SYS_CLK);
            ar = ARVALID & ARREADY; rv = RVALID & RREADY; rd = RDATA; rr = RRESP;
            @(posedge SYS_CLK);
            if (ar) ARVALID <= 1'b0;
            if (rv) begin
                RREADY <= 1'b0;
                break;
            end
        end
        if (n == 50) hang("read");
        chk(rd, e, "read data");
        chk({30'h0, rr}, {30'h0, er}, "read resp");
    endtask : rchk
    task go(input logic [3:0] hp, input logic t, input logic u, input logic e);
        @(posedge SYS_CLK);
        HP_EVENT <= hp; TURNOFF_RX <= t; UP_TLP_RX <= u; EE_LOAD <= e;
        @(posedge SYS_CLK);
        HP_EVENT <= 4'h0; TURNOFF_RX <= 1'b0; UP_TLP_RX <= 1'b0; EE_LOAD <= 1'b0;
    endtask : go
    task wt(input int b, input int lim);
        for (k = 0; k < lim; k++) begin
            @(negedge SYS_CLK);
            if (mon[b] === 1'b1) break;
        end
    endtask : wt
    task rst;
        @(posedge SYS_CLK);
        SRST <= 1'b1; PORT_ACTIVE <= 4'h0; silent <= 4'h0; UP_TLP_SELF <= 1'b0; UP_TLP_PORT <= 4'h0;
        repeat (6) @(posedge SYS_CLK);
        SRST <= 1'b0;
    endtask : rst
    task t_regs;
        rchk(`A_RETRY_TO, 32'h100, `OKAY);
        rchk(`A_ACK_TO, 32'h100, `OKAY);
        rchk(8'hfc, 32'h0, `SLVERR);
        wr(`A_NEXT_PTR, 32'h100);
        rchk(`A_PBHDR, 32'h0, `OKAY);
        wr(`A_PBHDR, 32'hffffffff);
        rchk(`A_PBHDR, 32'h0, `OKAY);
        EE_HDR <= 32'h00010004;
        go(4'h0, 1'b0, 1'b0, 1'b1);
        rchk(`A_PBHDR, 32'h00010004, `OKAY);
        wr(`A_CTRL, 32'h1);
        wr(8'h5c, 32'ha5a5);
        wr(`A_CTRL, 32'h0);
        wr(8'h5c, 32'h5a5a);
        rchk(8'h5c, 32'ha5a5, `OKAY);
        wr(`A_NEXT_PTR, 32'h0);
        rchk(`A_PBHDR, 32'h0, `OKAY);
        $display("test regs done");
    endtask : t_regs
    task t_pme;
        wr(`A_PWRST, 32'h3);
        go(4'h1, 1'b0, 1'b0, 1'b0);
        wt(4, 20);
        chk(k, 20, "pme in cold");
        wr(`A_PWRST, 32'h2);
        wr(`A_RETRY_TO, 32'h10);
        go(4'h2, 1'b0, 1'b0, 1'b0);
        wt(5, 5);
        chk(k < 5, 1, "pme from d3hot");
        wt(5, 40);
        chk(k, 16, "pme retry spacing");
        wr(`A_PME_FLAGS, 32'h2);
        wt(5, 60);
        chk(k, 60, "pme after clear");
        $display("test pme done");
    endtask : t_pme
    task t_ack;
        wr(`A_PWRST, 32'h2);
        wr(`A_ACK_TO, 32'h10);
        wr(`A_MASK, 32'h1);
        PORT_ACTIVE <= 4'h3;
        silent <= 4'h1;
        go(4'h0, 1'b1, 1'b0, 1'b0);
        wt(16, 4);
        chk(TURNOFF_TX, 4'h3, "turnoff fanout");
        wt(3, 30);
        chk(k >= 12 && k < 30, 1, "ack after timeout");
        chk(UP_L23, 1'b1, "upstream l23");
        rchk(`A_STAT, 32'h5, `OKAY);
        chk(IRQ, 1'b1, "irq set");
        wr(`A_MASK, 32'h0);
        chk(IRQ, 1'b0, "irq masked");
        wr(`A_STAT, 32'h5);
        rchk(`A_STAT, 32'h0, `OKAY);
        go(4'h0, 1'b0, 1'b1, 1'b0);
        wt(2, 4);
        chk(k < 4, 1, "drop after ack");
        wr(`A_PWRST, 32'h0);
        repeat (2) @(posedge SYS_CLK);
        chk(UP_L23, 1'b0, "re-armed in d0 uninit");
        $display("test ack done");
    endtask : t_ack
    task t_abandon;
        PORT_ACTIVE <= 4'h3;
        silent <= 4'h2;
        UP_TLP_SELF <= 1'b1;
        go(4'h0, 1'b1, 1'b0, 1'b0);
        repeat (10) @(posedge SYS_CLK);
        go(4'h0, 1'b0, 1'b1, 1'b0);
        wt(1, 4);
        chk(k < 4, 1, "self tlp answered");
        rchk(`A_STAT, 32'h2, `OKAY);
        UP_TLP_SELF <= 1'b0;
        UP_TLP_PORT <= 4'h1;
        go(4'h0, 1'b0, 1'b1, 1'b0);
        wt(12, 4);
        chk(k < 4, 1, "retrain l23 port");
        wt(8, 20);
        chk(k >= 3 && k < 20, 1, "forward after l0");
        UP_TLP_PORT <= 4'h4;
        go(4'h0, 1'b0, 1'b1, 1'b0);
        wt(10, 4);
        chk(k < 4 && RETRAIN === 4'h0, 1, "forward in l0");
        wt(3, 300);
        chk(k, 300, "no ack after abandon");
        $display("test abandon done");
    endtask : t_abandon
    initial begin
        rst();
        t_regs();
        rst();
        t_pme();
        rst();
        t_ack();
        rst();
        t_abandon();
        finish_test();
    end
endmodule : pme_fence_tb
